// ---- hw/osccfg_tick_cnt.sv ----
`timescale 1ns/1ps
// counts oscillator ticks up to a limit, saturating there
module osccfg_tick_cnt #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic clear,
	input wire logic tick,
	input wire logic [W-1:0] limit,
	// result
	output logic done
);
	import osccfg_pkg::*;

	typedef struct packed {
		logic [W-1:0] cnt; // ticks seen since clear
		logic done_ff; // count reached limit
	} osccfg_cnt_st_t;

	osccfg_cnt_st_t st_ff;
	osccfg_cnt_st_t nxt_st;

	// saturate so a long request never wraps back to closed
	always_comb begin
		nxt_st = st_ff;
		if (clear) begin
			nxt_st.cnt = '0;
		end else if (tick && (st_ff.cnt < limit)) begin
			nxt_st.cnt = st_ff.cnt + W'(1);
		end
		nxt_st.done_ff = !clear && (nxt_st.cnt >= limit);
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign done = st_ff.done_ff;
endmodule // osccfg_tick_cnt

// ---- hw/osccfg_top.sv ----
`timescale 1ns/1ps
// oscillator configuration and trim with an axi4-lite register slave
module osccfg_top #(
	parameter int SLOW_STARTUP_TICKS = 8,
	parameter int XTAL_SU_1K = 1024,
	parameter int XTAL_SU_16K = 16384,
	parameter int XTAL_SU_32K = 32768,
	parameter int XTAL_SU_64K = 65536
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// fuses and factory tables
	input wire osccfg_pkg::osccfg_fuse_t osc_config_fuse,
	input wire osccfg_pkg::osccfg_ftab_t factory_freq_tbl,
	input wire osccfg_pkg::osccfg_ttab_t factory_temp_tbl,
	// slow rc oscillator
	input wire logic slow_req,
	input wire logic slow_tick,
	output logic slow_rc_power,
	output logic slow_rc_gate,
	// crystal oscillator
	input wire logic xtal_req,
	input wire logic xtal_tick,
	output logic crystal_power,
	output logic crystal_gate,
	output logic crystal_pin_override,
	output logic crystal_ext_clock,
	output logic crystal_stable_flag,
	// fast rc trims
	output logic [5:0] freq_trim,
	output logic [3:0] temp_slope_trim
);
	import osccfg_pkg::*;

	typedef struct packed {
		logic [5:0] freq_trim; // fast rc frequency trim
		logic [3:0] temp_trim; // fast rc slope trim
		logic trim_lock; // fuse lock copy
		logic slow_krs; // slow rc keep running
		logic x_en; // crystal enable
		logic x_krs; // crystal keep running
		logic x_sel; // crystal source type
		logic [1:0] x_crystal_startup_count; // crystal start-up code
		logic [2:0] unlock_cnt; // protection window left
		logic aw_held; // address waiting for data
		logic [5:0] aw_idx; // held word index
		logic w_held; // data waiting for address
		logic [7:0] wbyte; // held low data byte
		logic wstrb0; // held low lane strobe
		logic awready; // address channel ready
		logic wready; // data channel ready
		logic bvalid; // write response valid
		logic [1:0] bresp; // write response code
		logic arready; // read address ready
		logic rvalid; // read data valid
		logic [7:0] rbyte; // read data byte
		logic [1:0] rresp; // read response code
		logic slow_pwr; // slow rc powered
		logic slow_gate; // slow rc output open
		logic x_pwr; // crystal powered
		logic [1:0] x_gcnt; // ticks since warm request
		logic x_gate; // crystal output open
		logic stable; // crystal stable flag
	} osccfg_st_t;

	osccfg_st_t st_ff;
	osccfg_st_t nxt_st;
	logic slow_done; // slow gate delay elapsed
	logic su_done; // crystal start-up count elapsed
	logic x_started; // crystal usable
	logic do_wr; // write performed this cycle
	osccfg_reg_t wr_reg; // decoded write target
	logic [7:0] slow_limit;
	logic [16:0] su_limit;

	// word index to register; shared by the read and write paths
	function automatic osccfg_reg_t decode(input logic [5:0] idx);
		unique case (idx)
			IDX_MAIN_STATUS: decode = REG_STAT;
			IDX_FREQ_TRIM: decode = REG_FREQ;
			IDX_TEMP_TRIM: decode = REG_TEMP;
			IDX_SLOW_CTRL: decode = REG_SLOW;
			IDX_XTAL_CTRL: decode = REG_XTAL;
			IDX_UNLOCK: decode = REG_UNLK;
			default: decode = REG_NONE;
		endcase
	endfunction

	// start-up length from the two-bit code
	always_comb begin
		unique case (st_ff.x_crystal_startup_count)
			2'h0: su_limit = 17'(XTAL_SU_1K); // R10
			2'h1: su_limit = 17'(XTAL_SU_16K); // R10
			2'h2: su_limit = 17'(XTAL_SU_32K); // R10
			2'h3: su_limit = 17'(XTAL_SU_64K); // R10
		endcase
	end

	// warm slow rc skips the analog start-up part
	assign slow_limit = st_ff.slow_krs ? 8'(SLOW_GATE_TICKS) :
		8'(SLOW_GATE_TICKS + SLOW_STARTUP_TICKS); // R7

	// slow rc gate delay counter, restarts with each request
	osccfg_tick_cnt #(.W(8)) u_slow_cnt (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(!slow_req),
		.tick(slow_tick),
		.limit(slow_limit),
		.done(slow_done)
	);

	// external clock needs no count, so counter is held clear
	osccfg_tick_cnt #(.W(17)) u_xtal_cnt (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(!st_ff.x_pwr || (st_ff.x_sel == SRC_EXT_CLOCK)),
		.tick(xtal_tick),
		.limit(su_limit),
		.done(su_done)
	);

	assign x_started = st_ff.x_pwr &&
		((st_ff.x_sel == SRC_EXT_CLOCK) || su_done); // R11 R12
	assign do_wr = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
	assign wr_reg = decode(st_ff.aw_idx);

	// next state: bus slave, register writes, oscillator control
	always_comb begin
		logic [7:0] wb;
		wb = st_ff.wbyte;
		nxt_st = st_ff;
		// protection window runs down by itself
		if (st_ff.unlock_cnt != 3'h0) begin
			nxt_st.unlock_cnt = st_ff.unlock_cnt - 3'h1;
		end
		// address and data are taken in either order
		if (awvalid && st_ff.awready) begin
			nxt_st.aw_held = 1'b1;
			nxt_st.aw_idx = awaddr[7:2];
		end
		if (wvalid && st_ff.wready) begin
			nxt_st.w_held = 1'b1;
			nxt_st.wbyte = wdata[7:0];
			nxt_st.wstrb0 = wstrb[0];
		end
		if (st_ff.bvalid && bready) begin
			nxt_st.bvalid = 1'b0;
		end
		if (do_wr) begin
			nxt_st.aw_held = 1'b0;
			nxt_st.w_held = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
			// only the low byte lane carries register bits
			if (st_ff.wstrb0) begin
				unique case (wr_reg)
					REG_FREQ: begin
						if (!st_ff.trim_lock) begin // R2
							nxt_st.freq_trim = wb[5:0]; // R1 R18
						end
					end
					REG_TEMP: begin
						if (!st_ff.trim_lock) begin // R2
							nxt_st.temp_trim = wb[3:0]; // R4 R18
						end
					end
					REG_SLOW: nxt_st.slow_krs = wb[SLOW_KRS_BIT];
					REG_XTAL: begin
						if (st_ff.unlock_cnt != 3'h0) begin // R16
							nxt_st.x_en = wb[XTAL_EN_BIT];
							nxt_st.x_krs = wb[XTAL_KRS_BIT];
							nxt_st.unlock_cnt = 3'h0;
						end
						if (!st_ff.x_en && !st_ff.stable) begin // R8 R15
							nxt_st.x_sel = wb[XTAL_SEL_BIT];
							nxt_st.x_crystal_startup_count = wb[XTAL_CRYSTAL_STARTUP_COUNT_LSB +: 2];
						end
					end
					REG_UNLK: begin
						if (wb == UNLOCK_KEY) begin // R16
							nxt_st.unlock_cnt = UNLOCK_CYCLES;
						end
					end
					default: begin
						// status and unmapped words ignore writes
					end
				endcase
			end
		end
		nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid;
		nxt_st.wready = !nxt_st.w_held && !nxt_st.bvalid;
		// read: one word at a time, answered the cycle after
		if (st_ff.rvalid && rready) begin
			nxt_st.rvalid = 1'b0;
		end
		if (arvalid && st_ff.arready) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = RESP_OKAY;
			nxt_st.rbyte = 8'h00; // R18
			unique case (decode(araddr[7:2]))
				REG_STAT: nxt_st.rbyte[STAT_XTAL_BIT] = st_ff.stable; // R17
				REG_FREQ: nxt_st.rbyte[5:0] = st_ff.freq_trim;
				REG_TEMP: begin
					nxt_st.rbyte[3:0] = st_ff.temp_trim;
					nxt_st.rbyte[TEMP_LOCK_BIT] = st_ff.trim_lock; // R2
				end
				REG_SLOW: nxt_st.rbyte[SLOW_KRS_BIT] = st_ff.slow_krs;
				REG_XTAL: begin
					nxt_st.rbyte[XTAL_EN_BIT] = st_ff.x_en;
					nxt_st.rbyte[XTAL_KRS_BIT] = st_ff.x_krs;
					nxt_st.rbyte[XTAL_SEL_BIT] = st_ff.x_sel;
					nxt_st.rbyte[XTAL_CRYSTAL_STARTUP_COUNT_LSB +: 2] = st_ff.x_crystal_startup_count;
				end
				REG_UNLK: nxt_st.rbyte = 8'h00;
				REG_NONE: nxt_st.rresp = RESP_SLVERR;
			endcase
		end
		nxt_st.arready = !nxt_st.rvalid;
		// slow rc: power on keep-running or request, gate on request
		nxt_st.slow_pwr = st_ff.slow_krs || slow_req; // R5
		nxt_st.slow_gate = slow_req && slow_done; // R6 R7
		// crystal: needs enable, then keep-running or a request
		nxt_st.x_pwr = st_ff.x_en && (st_ff.x_krs || xtal_req); // R13
		// warm gate counts two ticks, registered into the third
		if (!(xtal_req && x_started)) begin
			nxt_st.x_gcnt = 2'h0;
		end else if (xtal_tick && (st_ff.x_gcnt < XTAL_GATE_TICKS)) begin
			nxt_st.x_gcnt = st_ff.x_gcnt + 2'h1; // R14
		end
		nxt_st.x_gate = xtal_req && x_started &&
			(nxt_st.x_gcnt == XTAL_GATE_TICKS); // R14
		// flag hides a crystal that runs but is not requested
		nxt_st.stable = xtal_req && x_started; // R17
	end

	// state register; fuse loads happen on every reset cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
			st_ff.freq_trim <=
				factory_freq_tbl[osc_config_fuse.freq_select]; // R1
			st_ff.temp_trim <=
				factory_temp_tbl[osc_config_fuse.freq_select]; // R4
			st_ff.trim_lock <= osc_config_fuse.trim_lock; // R3
			st_ff.slow_krs <= SLOW_CTRL_RST[SLOW_KRS_BIT];
			st_ff.x_en <= XTAL_CTRL_RST[XTAL_EN_BIT];
			st_ff.x_krs <= XTAL_CTRL_RST[XTAL_KRS_BIT];
			st_ff.x_sel <= XTAL_CTRL_RST[XTAL_SEL_BIT];
			st_ff.x_crystal_startup_count <= XTAL_CTRL_RST[XTAL_CRYSTAL_STARTUP_COUNT_LSB +: 2];
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from the state register
	assign awready = st_ff.awready;
	assign wready = st_ff.wready;
	assign bvalid = st_ff.bvalid;
	assign bresp = st_ff.bresp;
	assign arready = st_ff.arready;
	assign rvalid = st_ff.rvalid;
	assign rdata = {24'h000000, st_ff.rbyte}; // R18
	assign rresp = st_ff.rresp;
	assign slow_rc_power = st_ff.slow_pwr;
	assign slow_rc_gate = st_ff.slow_gate;
	assign crystal_power = st_ff.x_pwr;
	assign crystal_gate = st_ff.x_gate;
	assign crystal_pin_override = st_ff.x_en; // R15
	assign crystal_ext_clock = st_ff.x_sel; // R12
	assign crystal_stable_flag = st_ff.stable;
	assign freq_trim = st_ff.freq_trim;
	assign temp_slope_trim = st_ff.temp_trim;

	// checks, all in the one clock domain
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_xtal_wr;
		do_wr && st_ff.wstrb0 && (wr_reg == REG_XTAL);
	endsequence
	sequence s_trim_wr;
		do_wr && st_ff.wstrb0 && (wr_reg inside {REG_FREQ, REG_TEMP});
	endsequence

	a_trim_lock_hold: assert property ( // R2
		s_trim_wr ##0 st_ff.trim_lock |=> $stable(st_ff.freq_trim) &&
			$stable(st_ff.temp_trim))
		else $error("trim changed while locked");
	a_lock_fuse_load: assert property ( // R3
		$rose(aresetn) |-> st_ff.trim_lock == $past(osc_config_fuse.trim_lock))
		else $error("lock not loaded from fuse");
	a_slow_keep_on: assert property ( // R5
		st_ff.slow_krs |=> slow_rc_power)
		else $error("slow rc off while keep-running");
	a_slow_gate_req: assert property ( // R6
		!slow_req |=> !slow_rc_gate)
		else $error("slow rc gate open without request");
	a_xtal_frozen: assert property ( // R8
		s_xtal_wr ##0 (st_ff.x_en || st_ff.stable) |=>
			$stable(st_ff.x_sel) && $stable(st_ff.x_crystal_startup_count))
		else $error("crystal source changed while running");
	a_xtal_need_key: assert property ( // R16
		s_xtal_wr ##0 (st_ff.unlock_cnt == 3'h0) |=> $stable(st_ff.x_en))
		else $error("crystal enable written without key");
	a_xtal_ext_skip: assert property ( // R11
		st_ff.x_pwr && st_ff.x_sel && xtal_req ##1 xtal_req |->
			crystal_stable_flag)
		else $error("external clock waited for start-up");
	a_xtal_warm_gate: assert property ( // R14
		crystal_stable_flag && xtal_req && xtal_tick ##1
			(xtal_req && xtal_tick && st_ff.x_pwr)[*2] |=> crystal_gate)
		else $error("warm crystal gate late");
	a_xtal_idle_off: assert property ( // R13
		!st_ff.x_en |=> !crystal_power)
		else $error("crystal powered while disabled");
	a_stable_req: assert property ( // R17
		crystal_stable_flag |-> $past(xtal_req))
		else $error("stable flag without request");
endmodule // osccfg_top

// ---- shared/osccfg_pkg.sv ----
// What this block does
// R1: six-bit frequency trim loaded from fuse table
// R2: lock bit blocks both trim register writes
// R3: lock bit reloaded from fuse every reset
// R4: four-bit temperature slope trim from fuse table
// R5: slow rc keep-running keeps it powered
// R6: slow rc output gated unless requested
// R7: gate opens four ticks after request when kept running; cold adds start-up ticks
// R8: source and count frozen while enabled/stable
// R9: software disables, waits unstable, then re-enables
// R10: two-bit code picks 1k/16k/32k/64k start-up
// R11: external clock source skips start-up count
// R12: source 0 crystal, 1 external clock
// R13: crystal runs always or only when requested
// R14: warm crystal delivered within 2-3 ticks
// R15: enable overrides pins, freezes source/count
// R16: enable and keep-running need unlock key
// R17: stable flag only when requested and stable
// R18: unused bits read zero, writes ignored
package osccfg_pkg;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_MAIN_STATUS = 6'h03;
	localparam logic [5:0] IDX_FREQ_TRIM = 6'h11;
	localparam logic [5:0] IDX_TEMP_TRIM = 6'h12;
	localparam logic [5:0] IDX_SLOW_CTRL = 6'h18;
	localparam logic [5:0] IDX_XTAL_CTRL = 6'h1c;
	localparam logic [5:0] IDX_UNLOCK = 6'h3f;

	// field positions
	localparam int TEMP_LOCK_BIT = 7;
	localparam int SLOW_KRS_BIT = 1;
	localparam int XTAL_EN_BIT = 0;
	localparam int XTAL_KRS_BIT = 1;
	localparam int XTAL_SEL_BIT = 2;
	localparam int XTAL_CRYSTAL_STARTUP_COUNT_LSB = 4;
	localparam int STAT_XTAL_BIT = 6;

	// reset values
	localparam logic [7:0] SLOW_CTRL_RST = 8'h00;
	localparam logic [7:0] XTAL_CTRL_RST = 8'h00;

	// write protection key and window length in clocks
	localparam logic [7:0] UNLOCK_KEY = 8'hd8;
	localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

	// oscillator tick counts
	localparam int SLOW_GATE_TICKS = 4;
	localparam logic [1:0] XTAL_GATE_TICKS = 2'h2;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// source type encodings
	localparam logic SRC_CRYSTAL = 1'h0;
	localparam logic SRC_EXT_CLOCK = 1'h1;

	// fuse contents captured at reset
	typedef struct packed {
		logic [1:0] freq_select;
		logic trim_lock;
	} osccfg_fuse_t;

	// factory trim tables, one entry per frequency select
	typedef logic [3:0][5:0] osccfg_ftab_t;
	typedef logic [3:0][3:0] osccfg_ttab_t;

	// decoded register
	typedef enum logic [2:0] {
		REG_NONE, REG_STAT, REG_FREQ, REG_TEMP, REG_SLOW, REG_XTAL, REG_UNLK
	} osccfg_reg_t;

endpackage

// ---- tb/osccfg_top_bench.sv ----
`timescale 1ns/1ps
// self-checking bench: drives the register bus and the oscillator side
module osccfg_top_bench;
	import osccfg_pkg::*;
	// byte addresses are four times the word index
	localparam logic [7:0] A_STAT = {IDX_MAIN_STATUS, 2'h0};
	localparam logic [7:0] A_FREQ = {IDX_FREQ_TRIM, 2'h0};
	localparam logic [7:0] A_TEMP = {IDX_TEMP_TRIM, 2'h0};
	localparam logic [7:0] A_SLOW = {IDX_SLOW_CTRL, 2'h0};
	localparam logic [7:0] A_XTAL = {IDX_XTAL_CTRL, 2'h0};
	localparam logic [7:0] A_UNLK = {IDX_UNLOCK, 2'h0};
	// clock and reset
	logic aclk = 1'b0, aresetn = 1'b0;
	// master side; ready held high, so every answer is taken at once
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic bready = 1'b1, rready = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h1;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] rdata;
	logic [1:0] bresp, rresp;
	// fuse and tables; rows differ so a wrong index shows
	osccfg_fuse_t osc_config_fuse = '0;
	osccfg_ftab_t factory_freq_tbl = {6'h2a, 6'h15, 6'h33, 6'h0c};
	osccfg_ttab_t factory_temp_tbl = {4'h9, 4'h6, 4'ha, 4'h3};
	// oscillator side
	logic slow_req = 1'b0, slow_tick = 1'b0;
	logic xtal_req = 1'b0, xtal_tick = 1'b0;
	logic slow_rc_power, slow_rc_gate, crystal_power, crystal_gate;
	logic crystal_pin_override, crystal_ext_clock, crystal_stable_flag;
	logic [5:0] freq_trim;
	logic [3:0] temp_slope_trim;
	// bookkeeping and last bus answer
	int fails = 0, check_count = 0;
	logic [31:0] rd;
	logic [1:0] rs;

	// start-up counts shortened to keep the run brief
	osccfg_top #(.SLOW_STARTUP_TICKS(2), .XTAL_SU_1K(4), .XTAL_SU_16K(8),
		.XTAL_SU_32K(12), .XTAL_SU_64K(16)) dut_u (
		.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
		.wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
		.arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
		.rresp, .osc_config_fuse, .factory_freq_tbl,
		.factory_temp_tbl, .slow_req, .slow_tick, .slow_rc_power,
		.slow_rc_gate, .xtal_req, .xtal_tick, .crystal_power,
		.crystal_gate, .crystal_pin_override, .crystal_ext_clock,
		.crystal_stable_flag, .freq_trim, .temp_slope_trim
	);

	// 4 ns clock
	initial begin
		forever #2 aclk = ~aclk;
	end

	// compare, count, report a mismatch at once
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 50);
		rs = bresp;
		if (n >= 50) chk(32'(n), 32'h0);
	endtask

	// read: wait for the answer, no fixed latency assumed
	task automatic rdr(input logic [7:0] a);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 50);
		rd = rdata;
		rs = rresp;
		if (n >= 50) chk(32'(n), 32'h0);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		rdr(a);
		chk(rd, {24'h0, e});
	endtask

	// key write opens the protection window for the next control write
	task automatic uwr(input logic [7:0] d);
		wr(A_UNLK, UNLOCK_KEY);
		wr(A_XTAL, d);
	endtask

	// one-cycle tick pulses on the slow (0) or crystal (1) input
	task automatic tk(input bit x, input int n);
		repeat (n) begin
			if (x) xtal_tick <= 1'b1;
			else slow_tick <= 1'b1;
			@(posedge aclk);
			xtal_tick <= 1'b0;
			slow_tick <= 1'b0;
			@(posedge aclk);
		end
	endtask

	// fuse is sampled on every reset edge
	task automatic rst(input logic lk, input logic [1:0] fs);
		osc_config_fuse <= '{freq_select: fs, trim_lock: lk};
		aresetn <= 1'b0;
		cyc(5);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask

	task automatic t_reset();
		rst(1'b0, 2'h2);
		chk(32'(freq_trim), 32'(factory_freq_tbl[2]));
		chk(32'(temp_slope_trim), 32'(factory_temp_tbl[2]));
		rchk(A_FREQ, {2'h0, factory_freq_tbl[2]});
		rchk(A_TEMP, {4'h0, factory_temp_tbl[2]});
		rchk(A_SLOW, SLOW_CTRL_RST);
		rchk(A_XTAL, XTAL_CTRL_RST);
		rchk(A_STAT, 8'h00);
	endtask

	// unlocked trims take writes; spare bits stay zero; holes refused
	task automatic t_trim();
		wr(A_FREQ, 8'hff);
		chk(32'(rs), 32'(RESP_OKAY));
		rchk(A_FREQ, 8'h3f);
		chk(32'(freq_trim), 32'h3f);
		// a write with the low lane strobe off leaves the trim alone
		wstrb <= 4'h0;
		wr(A_FREQ, 8'h00);
		wstrb <= 4'h1;
		rchk(A_FREQ, 8'h3f);
		wr(A_TEMP, 8'hff);
		rchk(A_TEMP, 8'h0f);
		chk(32'(temp_slope_trim), 32'hf);
		wr(8'h20, 8'h55);
		chk(32'(rs), 32'(RESP_SLVERR));
		rdr(8'h20);
		chk(32'(rs), 32'(RESP_SLVERR));
		chk(rd, 32'h0);
	endtask

	// fuse lock: both trims frozen; lock reloaded at every reset
	task automatic t_lock();
		rst(1'b1, 2'h1);
		rchk(A_TEMP, {4'h8, factory_temp_tbl[1]});
		wr(A_FREQ, 8'h00);
		wr(A_TEMP, 8'h00);
		chk(32'(freq_trim), 32'(factory_freq_tbl[1]));
		rchk(A_TEMP, {4'h8, factory_temp_tbl[1]});
		rst(1'b0, 2'h0);
		rchk(A_TEMP, {4'h0, factory_temp_tbl[0]});
		chk(32'(freq_trim), 32'(factory_freq_tbl[0]));
	endtask

	// request, one tick short stays shut, the last tick opens the gate
	task automatic slow_gate_run(input int n);
		slow_req <= 1'b1;
		tk(1'b0, n - 1);
		cyc(4);
		chk(32'(slow_rc_gate), 32'h0);
		tk(1'b0, 1);
		cyc(3);
		chk(32'(slow_rc_gate), 32'h1);
		slow_req <= 1'b0;
	endtask

	task automatic t_slow();
		wr(A_SLOW, 8'hff);
		rchk(A_SLOW, 8'h02);
		chk(32'(slow_rc_power), 32'h1);
		chk(32'(slow_rc_gate), 32'h0);
		slow_gate_run(SLOW_GATE_TICKS);
		wr(A_SLOW, 8'h00);
		// power follows the control bit one registered cycle later
		cyc(2);
		chk(32'(slow_rc_power), 32'h0);
		chk(32'(slow_rc_gate), 32'h0);
		slow_gate_run(SLOW_GATE_TICKS + 2);
	endtask

	// every start-up code: disable, recode, enable, count the ticks
	task automatic t_xtal_codes();
		logic [7:0] v;
		wr(A_XTAL, 8'h03);
		rchk(A_XTAL, 8'h00);
		for (int c = 0; c < 4; c++) begin
			v = {2'h0, c[1:0], 4'h0};
			uwr(v);
			chk(32'(crystal_pin_override), 32'h0);
			wr(A_XTAL, v | 8'h08);
			uwr(v | 8'h03);
			rchk(A_XTAL, v | 8'h03);
			chk(32'(crystal_pin_override), 32'h1);
			xtal_req <= 1'b1;
			tk(1'b1, 4 * c + 3);
			cyc(4);
			chk(32'(crystal_stable_flag), 32'h0);
			tk(1'b1, 1);
			cyc(3);
			chk(32'(crystal_stable_flag), 32'h1);
			xtal_req <= 1'b0;
		end
	endtask

	// warm crystal: fields frozen, quick gate, power kept in standby
	task automatic t_xtal_run();
		chk(32'(crystal_ext_clock), 32'(SRC_CRYSTAL));
		wr(A_XTAL, 8'h27);
		rchk(A_XTAL, 8'h33);
		xtal_req <= 1'b1;
		cyc(3);
		chk(32'(crystal_stable_flag), 32'h1);
		rchk(A_STAT, 8'h40);
		chk(32'(crystal_gate), 32'h0);
		tk(1'b1, 2);
		cyc(3);
		chk(32'(crystal_gate), 32'h1);
		xtal_req <= 1'b0;
		cyc(3);
		chk(32'(crystal_gate), 32'h0);
		chk(32'(crystal_power), 32'h1);
		rchk(A_STAT, 8'h00);
		// fresh request with back-to-back ticks: gate after two of them
		xtal_req <= 1'b1;
		cyc(3);
		xtal_tick <= 1'b1;
		cyc(2);
		chk(32'(crystal_gate), 32'h0);
		cyc(1);
		chk(32'(crystal_gate), 32'h1);
		xtal_tick <= 1'b0;
		xtal_req <= 1'b0;
	endtask

	// external clock source: stable with no start-up ticks at all
	task automatic t_xtal_ext();
		uwr(8'h00);
		wr(A_XTAL, 8'h04);
		rchk(A_XTAL, 8'h04);
		chk(32'(crystal_ext_clock), 32'(SRC_EXT_CLOCK));
		uwr(8'h05);
		chk(32'(crystal_power), 32'h0);
		xtal_req <= 1'b1;
		cyc(4);
		chk(32'(crystal_power), 32'h1);
		chk(32'(crystal_stable_flag), 32'h1);
		xtal_req <= 1'b0;
		// without keep-running the crystal stops with its request
		cyc(3);
		chk(32'(crystal_power), 32'h0);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// the sequence needs about 340 clocks; a hang is cut at 20000
	initial begin
		cyc(20000);
		fails++;
		finish_test();
	end

	initial begin
		t_reset();
		t_trim();
		t_lock();
		t_slow();
		t_xtal_codes();
		t_xtal_run();
		t_xtal_ext();
		finish_test();
	end
endmodule // osccfg_top_bench
